// ==== logic/dtc_delay_line.sv ====
// Purpose: Shift line stepped by an enable, tapped at a chosen depth
// Assumes: Tap below DEPTH
// Notes: Tap 0 is the value shifted in at the last step
`timescale 1ns/1ns
module dtc_delay_line #(
   parameter int DEPTH = 32
) (
   clk,
   resetn,
   step,
   din,
   tap,
   dout
);
   input wire logic clk;
   input wire logic resetn;
   input wire logic step;
   input wire logic din;
   input wire logic [4:0] tap;
   output logic dout;
   logic [DEPTH-1:0] line_r;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         line_r <= '0;
      end else if (step) begin
         line_r <= {line_r[DEPTH-2:0], din};
      end
   end
   assign dout = line_r[tap];
endmodule : dtc_delay_line

// ==== logic/dtc_pkg.sv ====
// Purpose: Shared constants and types of the termination timing control
// Assumes: 100 MHz system clock, memory clock sampled as a plain input
// Notes: Register offsets are byte addresses on APB
package dtc_pkg;
   // ==========================================
   // Register map
   localparam logic [11:0] DTC_OFS_MODE_REG_ZERO = 12'h000;
   localparam logic [11:0] DTC_OFS_MODE_REG_ONE = 12'h004;
   localparam logic [11:0] DTC_OFS_MODE_REG_TWO = 12'h008;
   localparam logic [11:0] DTC_OFS_CTRL = 12'h00C;
   localparam logic [11:0] DTC_OFS_STATUS = 12'h010;
   localparam logic [15:0] DTC_RST_MODE_REG_ZERO = 16'h0000;
   localparam logic [15:0] DTC_RST_MODE_REG_ONE = 16'h0000;
   localparam logic [15:0] DTC_RST_MODE_REG_TWO = 16'h0000;
   localparam logic [1:0] DTC_RST_CTRL = 2'h0;
   // ==========================================
   // Field positions
   localparam int DTC_MODE0_CL_LO = 4;
   localparam int DTC_MODE0_DLL_PD = 12;
   localparam int DTC_MODE1_NOM_A2 = 2;
   localparam int DTC_MODE1_NOM_A6 = 6;
   localparam int DTC_MODE1_NOM_A9 = 9;
   localparam int DTC_MODE1_AL_LO = 3;
   localparam int DTC_MODE2_CWL_LO = 3;
   localparam int DTC_MODE2_WR_LO = 9;
   localparam int DTC_CTRL_DLL_ON = 0;
   localparam int DTC_CTRL_PRE_PD = 1;
   // ==========================================
   // Latency figures in memory clock cycles
   localparam logic [5:0] DTC_CL_BASE = 6'h04;
   localparam logic [5:0] DTC_CWL_BASE = 6'h05;
   localparam logic [5:0] DTC_LAT_SUB = 6'h02;
   localparam logic [5:0] DTC_WR_EXTRA_CHOP = 6'h04;
   localparam logic [5:0] DTC_WR_EXTRA_FULL = 6'h06;
   localparam int DTC_LINE_DEPTH = 32;
   // ==========================================
   // Asynchronous delay window, ns, and its cycle count at the system clock
   localparam real DTC_CLK_NS = 10.0;
   localparam real DTC_ASYNC_MAX_NS = 8.5;
   localparam int DTC_ASYNC_CYC_RAW = int'($floor(DTC_ASYNC_MAX_NS / DTC_CLK_NS));
   localparam int DTC_ASYNC_CYC = (DTC_ASYNC_CYC_RAW < 1) ? 1 : DTC_ASYNC_CYC_RAW;
   // ==========================================
   // Sampled pins and termination setting of the memory side
   typedef struct packed {
      logic ck;
      logic odt;
      logic wr;
      logic chop;
   } dtc_pins_t;
   typedef struct packed {
      logic term_on;
      logic use_write;
      logic [2:0] nominal;
      logic [1:0] write_val;
   } dtc_term_t;
endpackage : dtc_pkg

// ==== logic/dtc_sync.sv ====
// Purpose: Two-stage synchroniser for a group of pins
// Assumes: Inputs are asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ns
module dtc_sync #(
   parameter int W = 4
) (
   clk,
   resetn,
   d,
   q
);
   input wire logic clk;
   input wire logic resetn;
   input wire logic [W-1:0] d;
   output logic [W-1:0] q;
   logic [W-1:0] meta_r;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : dtc_sync

// ==== logic/dtc_term_ctrl.sv ====
// Purpose: On-die termination on/off and strength control of a DDR memory
// Assumes: Memory clock arrives as a pin, sampled and edge-detected on clk
// Notes: Latencies count rising memory clock edges; half-cycle offsets are not modelled.
//    Asynchronous response lags the pin by the synchroniser, so 8.5 ns cannot be met.
//    The memory clock must run well below clk for its edges to be found.
//
// Notes on behaviour
// - Synchronous mode: termination turns on write latency minus two after pin high.
// - Synchronous mode: termination turns off write latency minus two after pin low.
// - After a read, termination returns when the device stops driving data.
// - Dynamic termination enabled when write-termination bit 9 or 10 is set.
// - Nominal value from mode one bits 9,6,2; write value from mode two 10,9.
// - Without writes, nominal strength applies, switched by pin through latencies.
// - Dynamic enabled: write strength selected write latency minus two after a write.
// - Nominal returns off-latency plus 4 (chop) or plus 6 (full) after write.
// - Off and strength points nominally half a cycle late; skew 0.3 to 0.7.
// - Asynchronous control in precharge power-down when mode zero bit 12 clear.
// - Asynchronous mode applies no additive latency to the pin.
// - Asynchronous mode follows the sampled pin through one clk cycle of delay and the output register, with no memory clock latency.
// - Synchronous control whenever the loop is on and locked.
// - Synchronous latencies equal write latency plus additive latency minus two.
// - Asynchronous turn on or off completes 2 to 8.5 ns after the pin.
// - Pin ignored when every nominal and write termination bit is zero.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module dtc_term_ctrl (
   clk,
   resetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   mem_pins,
   dev_driving,
   term
);
   import dtc_pkg::*;
   input wire logic clk;
   input wire logic resetn;
   input wire logic psel;
   input wire logic penable;
   input wire logic pwrite;
   input wire logic [11:0] paddr;
   input wire logic [31:0] pwdata;
   output logic [31:0] prdata;
   output logic pready;
   output logic pslverr;
   input wire dtc_pkg::dtc_pins_t mem_pins;
   input wire logic dev_driving;
   output dtc_pkg::dtc_term_t term;

   // ==========================================
   // Register file
   logic [15:0] mode_reg_zero_r;
   logic [15:0] mode_reg_one_r;
   logic [15:0] mode_reg_two_r;
   logic [1:0] ctrl_r;
   logic setup_ok;
   logic hit_map;
   logic async_mode_r;
   logic [31:0] rd_word;

   assign setup_ok = psel && !penable;
   always_comb begin
      case (paddr)
         DTC_OFS_MODE_REG_ZERO, DTC_OFS_MODE_REG_ONE, DTC_OFS_MODE_REG_TWO,
         DTC_OFS_CTRL, DTC_OFS_STATUS: begin
            hit_map = 1'b1;
         end
         default: begin
            hit_map = 1'b0;
         end
      endcase
   end

   // Writes land in the setup cycle's following access edge
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mode_reg_zero_r <= DTC_RST_MODE_REG_ZERO;
         mode_reg_one_r <= DTC_RST_MODE_REG_ONE;
         mode_reg_two_r <= DTC_RST_MODE_REG_TWO;
         ctrl_r <= DTC_RST_CTRL;
      end else if (psel && penable && pready && pwrite) begin
         case (paddr)
            DTC_OFS_MODE_REG_ZERO: begin
               mode_reg_zero_r <= pwdata[15:0];
            end
            DTC_OFS_MODE_REG_ONE: begin
               mode_reg_one_r <= pwdata[15:0];
            end
            DTC_OFS_MODE_REG_TWO: begin
               mode_reg_two_r <= pwdata[15:0];
            end
            DTC_OFS_CTRL: begin
               ctrl_r <= pwdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // No wait state: pready rises the cycle after setup, for one cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ok;
         pslverr <= setup_ok && !hit_map;
      end
   end

   // Read word of the addressed register
   always_comb begin
      case (paddr)
         DTC_OFS_MODE_REG_ZERO: begin
            rd_word = {16'h0000, mode_reg_zero_r};
         end
         DTC_OFS_MODE_REG_ONE: begin
            rd_word = {16'h0000, mode_reg_one_r};
         end
         DTC_OFS_MODE_REG_TWO: begin
            rd_word = {16'h0000, mode_reg_two_r};
         end
         DTC_OFS_CTRL: begin
            rd_word = {30'h0000_0000, ctrl_r};
         end
         DTC_OFS_STATUS: begin
            rd_word = {29'h0000_0000, async_mode_r, term.use_write, term.term_on};
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // Read data is loaded at setup and stands until the next setup
   always_ff @(posedge clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup_ok) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
   end

   // ==========================================
   // Decoded mode fields
   logic [2:0] nominal_val;
   logic [1:0] write_val;
   logic dyn_en;
   logic term_allowed;
   logic [5:0] cl_cyc;
   logic [5:0] cwl_cyc;
   logic [5:0] al_cyc;
   logic [5:0] lat_cyc;
   logic [4:0] lat_tap;

   assign nominal_val = {mode_reg_one_r[DTC_MODE1_NOM_A9], mode_reg_one_r[DTC_MODE1_NOM_A6],
                         mode_reg_one_r[DTC_MODE1_NOM_A2]};
   assign write_val = mode_reg_two_r[DTC_MODE2_WR_LO +: 2];
   assign dyn_en = |write_val;
   assign term_allowed = (|nominal_val) || dyn_en;
   assign cl_cyc = DTC_CL_BASE + {3'h0, mode_reg_zero_r[DTC_MODE0_CL_LO +: 3]};
   assign cwl_cyc = DTC_CWL_BASE + {3'h0, mode_reg_two_r[DTC_MODE2_CWL_LO +: 3]};

   always_comb begin
      case (mode_reg_one_r[DTC_MODE1_AL_LO +: 2])
         2'h1: begin
            al_cyc = cl_cyc - 6'h01;
         end
         2'h2: begin
            al_cyc = cl_cyc - 6'h02;
         end
         default: begin
            al_cyc = 6'h00;
         end
      endcase
   end

   // Same figure serves on, off and nominal-to-write latency
   assign lat_cyc = cwl_cyc + al_cyc - DTC_LAT_SUB;
   // A registered sample is already one step deep in the line
   assign lat_tap = lat_cyc[4:0] - 5'h01;

   // ==========================================
   // Pin sampling and memory clock edges
   dtc_pins_t pins_s;
   logic ck_d_r;
   logic ck_rise;

   dtc_sync #(
      .W(4)
   ) u_pin_sync (
      .clk(clk),
      .resetn(resetn),
      .d(mem_pins),
      .q(pins_s)
   );

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ck_d_r <= 1'b0;
      end else begin
         ck_d_r <= pins_s.ck;
      end
   end
   // Edge taken after the synchroniser, so the command pins sampled with it are settled
   assign ck_rise = pins_s.ck && !ck_d_r;

   // Pin and command as registered at a rising memory clock edge
   logic odt_reg_r;
   logic wr_reg_r;
   logic chop_reg_r;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         odt_reg_r <= 1'b0;
         wr_reg_r <= 1'b0;
         chop_reg_r <= 1'b0;
      end else if (ck_rise) begin
         odt_reg_r <= pins_s.odt;
         wr_reg_r <= pins_s.wr;
         chop_reg_r <= pins_s.chop;
      end
   end

   // ==========================================
   // Mode selection
   always_ff @(posedge clk) begin
      if (!resetn) begin
         async_mode_r <= 1'b0;
      end else begin
         // Loop frozen only in precharge power-down with bit 12 clear
         async_mode_r <= ctrl_r[DTC_CTRL_PRE_PD] && !mode_reg_zero_r[DTC_MODE0_DLL_PD];
      end
   end
   logic sync_mode;
   assign sync_mode = ctrl_r[DTC_CTRL_DLL_ON] && !async_mode_r;

   // ==========================================
   // Synchronous on/off path
   logic odt_late;
   dtc_delay_line #(
      .DEPTH(DTC_LINE_DEPTH)
   ) u_odt_line (
      .clk(clk),
      .resetn(resetn),
      .step(ck_rise),
      .din(odt_reg_r),
      .tap(lat_tap),
      .dout(odt_late)
   );

   // ==========================================
   // Asynchronous path: short fixed delay, no additive latency
   logic [DTC_ASYNC_CYC-1:0] async_line_r;
   generate
      if (DTC_ASYNC_CYC == 1) begin : g_async_one
         always_ff @(posedge clk) begin
            if (!resetn) begin
               async_line_r <= '0;
            end else begin
               async_line_r <= pins_s.odt;
            end
         end
      end else begin : g_async_many
         // Several steps only when the clock period is short against the window
         always_ff @(posedge clk) begin
            if (!resetn) begin
               async_line_r <= '0;
            end else begin
               async_line_r <= {async_line_r[DTC_ASYNC_CYC-2:0], pins_s.odt};
            end
         end
      end
   endgenerate

   // ==========================================
   // Dynamic strength window after a write
   logic [5:0] wr_cnt_r;
   logic wr_active_r;
   logic wr_chop_r;
   logic [5:0] wr_end;
   assign wr_end = lat_cyc + (wr_chop_r ? DTC_WR_EXTRA_CHOP : DTC_WR_EXTRA_FULL);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_cnt_r <= 6'h00;
         wr_active_r <= 1'b0;
         wr_chop_r <= 1'b0;
      end else if (ck_rise) begin
         if (wr_reg_r && sync_mode) begin
            // Any write variant restarts the window; count is steps since it was registered
            wr_cnt_r <= 6'h01;
            wr_active_r <= 1'b1;
            wr_chop_r <= chop_reg_r;
         end else if (wr_active_r) begin
            if (wr_cnt_r >= wr_end) begin
               wr_active_r <= 1'b0;
            end else begin
               wr_cnt_r <= wr_cnt_r + 6'h01;
            end
         end
      end
   end

   logic use_write;
   // Window covers counts lat .. lat+4/6-1
   assign use_write = dyn_en && sync_mode && wr_active_r && (wr_cnt_r >= lat_cyc) &&
                      (wr_cnt_r < wr_end);

   // ==========================================
   // Output stage
   logic term_nxt;
   always_comb begin
      if (!term_allowed) begin
         term_nxt = 1'b0;
      end else if (dev_driving) begin
         // Terminating while driving would load the device's own output
         term_nxt = 1'b0;
      end else if (async_mode_r) begin
         term_nxt = async_line_r[DTC_ASYNC_CYC-1];
      end else if (sync_mode) begin
         term_nxt = odt_late;
      end else begin
         term_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         term <= '0;
      end else begin
         term.term_on <= term_nxt;
         term.use_write <= use_write && term_nxt;
         term.nominal <= nominal_val;
         term.write_val <= write_val;
      end
   end
endmodule : dtc_term_ctrl

// ==== testbench/dtc_mc_model.sv ====
// Purpose: Memory controller model driving clock and control pins
// Assumes: Memory clock is eight system clocks, free running
// Notes: Pins change mid low phase of the memory clock
`timescale 1ns/1ns
module dtc_mc_model (
   clk,
   resetn,
   odt_req,
   wr_req,
   chop_req,
   pins
);
   import dtc_pkg::*;
   input wire logic clk;
   input wire logic resetn;
   input wire logic odt_req;
   input wire logic wr_req;
   input wire logic chop_req;
   output dtc_pkg::dtc_pins_t pins;
   logic [2:0] ph_r;
   logic [2:0] hold_r;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ph_r <= 3'h0;
         hold_r <= 3'h0;
         pins <= '0;
      end else begin
         ph_r <= ph_r + 3'h1;
         pins.ck <= ~ph_r[2];
         if (ph_r == 3'h6) begin
            pins.odt <= odt_req || hold_r != 3'h0;
            pins.wr <= wr_req;
            pins.chop <= chop_req;
            if (wr_req && odt_req) begin
               hold_r <= chop_req ? 3'h3 : 3'h5;
            end else if (odt_req && !pins.odt) begin
               hold_r <= 3'h3;
            end else if (hold_r != 3'h0) begin
               hold_r <= hold_r - 3'h1;
            end
         end
      end
   end
endmodule : dtc_mc_model

// ==== testbench/dtc_term_ctrl_sva.sv ====
// Purpose: Port-level checks of the termination timing control
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound into every instance of the top module
`timescale 1ns/1ns
module dtc_term_ctrl_sva (
   clk,
   resetn,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   mem_pins,
   dev_driving,
   term
);
   import dtc_pkg::*;
   input wire logic clk;
   input wire logic resetn;
   input wire logic psel;
   input wire logic penable;
   input wire logic pwrite;
   input wire logic [11:0] paddr;
   input wire logic [31:0] pwdata;
   input wire logic [31:0] prdata;
   input wire logic pready;
   input wire logic pslverr;
   input wire dtc_pkg::dtc_pins_t mem_pins;
   input wire logic dev_driving;
   input wire dtc_pkg::dtc_term_t term;
   logic [5:0] uw_cnt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ====
   // Length of the write strength window
   always_ff @(posedge clk) begin
      if (!resetn || !term.use_write) begin
         uw_cnt_r <= 6'h00;
      end else if (uw_cnt_r != 6'h3F) begin
         uw_cnt_r <= uw_cnt_r + 6'h01;
      end
   end
   property p_ready; psel && !penable |=> pready; endproperty
   property p_pulse; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_unmap; psel && !penable && paddr > 12'h010 |=> pslverr; endproperty
   property p_unmap_rd; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
   property p_read_off; dev_driving |=> !term.term_on; endproperty
   property p_no_term; term.nominal == 3'h0 && term.write_val == 2'h0 |-> !term.term_on; endproperty
   property p_dyn; term.use_write |-> term.write_val != 2'h0; endproperty
   property p_nom;
      psel && penable && pready && pwrite && paddr == DTC_OFS_MODE_REG_ONE
         |-> ##2 term.nominal == {$past(pwdata[9], 2), $past(pwdata[6], 2), $past(pwdata[2], 2)};
   endproperty
   property p_uw_len; $fell(term.use_write) |-> uw_cnt_r >= 6'h1F && uw_cnt_r <= 6'h31; endproperty
   a_ready: assert property (p_ready) else $error("no answer after setup");
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
   a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read not zero");
   a_read_off: assert property (p_read_off) else $error("termination on while driving");
   a_no_term: assert property (p_no_term) else $error("termination on while disabled");
   a_dyn: assert property (p_dyn) else $error("write strength without write value");
   a_nom: assert property (p_nom) else $error("nominal code wrong");
   a_uw_len: assert property (p_uw_len) else $error("write strength window length wrong");
   c_write: cover property ($rose(term.use_write));
   c_read: cover property (dev_driving && term.term_on);
   c_err: cover property (pslverr);
endmodule : dtc_term_ctrl_sva

bind dtc_term_ctrl dtc_term_ctrl_sva u_sva (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .mem_pins(mem_pins), .dev_driving(dev_driving), .term(term));

// ==== testbench/dtc_term_ctrl_tb.sv ====
// Purpose: Self-checking bench of the termination timing control
// Assumes: Latency windows allow a few cycles of pipeline
// Notes: A memory clock edge is eight system clocks
`timescale 1ns/1ns
module dtc_term_ctrl_tb;
   import dtc_pkg::*;
   logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
   logic odt_req, wr_req, chop_req, dev_driving;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   dtc_pins_t pins;
   dtc_term_t term;
   int errors, comparisons, n, d;
   dtc_term_ctrl DUT (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_pins(pins), .dev_driving(dev_driving), .term(term));
   dtc_mc_model u_mc (.clk(clk), .resetn(resetn), .odt_req(odt_req), .wr_req(wr_req),
      .chop_req(chop_req), .pins(pins));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic rng(input int v, input int lo, input int hi);
      chk({31'h0, v >= lo && v <= hi}, 32'h1);
   endtask : rng
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_for(input logic uw, input logic v, output int k);
      k = 0;
      while ((uw ? term.use_write : term.term_on) !== v && k < 400) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_for
   // Rise time from the pin change, then how long the output stayed high
   task automatic pulse(input logic wr, input logic chop);
      odt_req <= 1'b1;
      wr_req <= wr;
      chop_req <= chop;
      while (pins.odt !== 1'b1) @(posedge clk);
      odt_req <= 1'b0;
      wr_req <= 1'b0;
      wait_for(wr, 1'b1, n);
      wait_for(wr, 1'b0, d);
      repeat (120) @(posedge clk);
   endtask : pulse
   task automatic close_out;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end
   initial begin
      {psel, penable, pwrite, odt_req, wr_req, chop_req, dev_driving} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      resetn = 1'b0;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk({25'h0, term}, 32'h0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 12'(i * 4), 32'h0);
         chk(q, 32'h0);
         chk({31'h0, err}, {31'h0, i == 5});
      end
      apb(1'b1, 12'h014, 32'hFFFF);
      chk({31'h0, err}, 32'h1);
      $display("test registers done");
      apb(1'b1, DTC_OFS_MODE_REG_ONE, 32'h240);
      apb(1'b1, DTC_OFS_MODE_REG_TWO, 32'h200);
      apb(1'b1, DTC_OFS_CTRL, 32'h1);
      apb(1'b0, DTC_OFS_MODE_REG_ONE, 32'h0);
      chk(q, 32'h240);
      chk({29'h0, term.nominal}, 32'h6);
      chk({30'h0, term.write_val}, 32'h1);
      pulse(1'b0, 1'b0);
      rng(n, 26, 33);
      rng(d, 31, 33);
      pulse(1'b1, 1'b1);
      rng(n, 26, 33);
      rng(d, 31, 33);
      apb(1'b1, DTC_OFS_MODE_REG_TWO, 32'h400);
      pulse(1'b1, 1'b0);
      rng(d, 47, 49);
      $display("test sync done");
      apb(1'b1, DTC_OFS_MODE_REG_ONE, 32'h248);
      pulse(1'b0, 1'b0);
      rng(n, 50, 57);
      odt_req <= 1'b1;
      wait_for(1'b0, 1'b1, n);
      dev_driving <= 1'b1;
      repeat (2) @(posedge clk);
      chk({31'h0, term.term_on}, 32'h0);
      dev_driving <= 1'b0;
      repeat (2) @(posedge clk);
      chk({31'h0, term.term_on}, 32'h1);
      odt_req <= 1'b0;
      repeat (120) @(posedge clk);
      dev_driving <= 1'b1;
      repeat (4) @(posedge clk);
      chk({31'h0, term.term_on}, 32'h0);
      dev_driving <= 1'b0;
      repeat (2) @(posedge clk);
      $display("test additive done");
      apb(1'b1, DTC_OFS_MODE_REG_TWO, 32'h0);
      apb(1'b1, DTC_OFS_CTRL, 32'h3);
      apb(1'b0, DTC_OFS_STATUS, 32'h0);
      chk({31'h0, q[2]}, 32'h1);
      pulse(1'b0, 1'b0);
      rng(n, 1, 8);
      apb(1'b1, DTC_OFS_MODE_REG_ZERO, 32'h1000);
      pulse(1'b0, 1'b0);
      rng(n, 50, 57);
      $display("test power-down done");
      pulse(1'b1, 1'b0);
      rng(n, 400, 400);
      apb(1'b1, DTC_OFS_MODE_REG_ONE, 32'h0);
      pulse(1'b0, 1'b0);
      rng(n, 400, 400);
      $display("test disabled done");
      close_out();
   end
endmodule : dtc_term_ctrl_tb
